// >>> rtl/cmd_buf_pkg.sv
package cmd_buf_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W    = 22;
    localparam int unsigned BUF_DEPTH = 2;
    localparam int unsigned CNT_W     = 2;

    // ------------------------------------------------------------
    // Reset values and cycle counts
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RESET   = 22'h000000;
    localparam logic [1:0]        PAIR_RESET   = 2'h0;
    localparam logic              PERR_IDLE_N  = 1'b1;
    localparam int unsigned       ERR_MIN_LOW  = 2;
    localparam int unsigned       LPM_TAIL     = 2;
    localparam logic [CNT_W-1:0]  ERR_HOLD_CNT = CNT_W'(ERR_MIN_LOW - 1);
    localparam logic [CNT_W-1:0]  LPM_HOLD_CNT = CNT_W'(LPM_TAIL);
    localparam logic [CNT_W-1:0]  CNT_ZERO     = 2'h0;
    localparam logic [CNT_W-1:0]  CNT_ONE      = 2'h1;
    localparam logic [CNT_W-1:0]  CNT_FULL     = CNT_W'(BUF_DEPTH);

    // Even parity over data plus parity bit: high means error
    function automatic logic parity_odd(input logic [DATA_W-1:0] word,
                                        input logic              par);
        parity_odd = (^word) ^ par;
    endfunction : parity_odd

endpackage : cmd_buf_pkg

// >>> rtl/word_stream_if.sv
`timescale 1ns/1ps
interface word_stream_if import cmd_buf_pkg::*; ();
    logic              valid;
    logic              ready;
    logic [DATA_W-1:0] data;

    modport producer (output valid, output data, input ready);
    modport consumer (input valid, input data, output ready);
endinterface : word_stream_if

// >>> rtl/word_buffer.sv
`timescale 1ns/1ps
module word_buffer import cmd_buf_pkg::*; (
    input  wire logic       clk,
    input  wire logic       reset,
    word_stream_if.consumer fill,
    word_stream_if.producer drain
);

    logic [DATA_W-1:0] head_q;
    logic [DATA_W-1:0] head_d;
    logic [DATA_W-1:0] tail_q;
    logic [DATA_W-1:0] tail_d;
    logic [CNT_W-1:0]  count_q;
    logic [CNT_W-1:0]  count_d;
    logic              push;
    logic              pop;

    // Head doubles as the output register, so no latency is added
    assign fill.ready  = (count_q != CNT_FULL);
    assign drain.valid = (count_q != CNT_ZERO);
    assign drain.data  = head_q;
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.ready && drain.valid;

    always_comb begin
        head_d  = head_q;
        tail_d  = tail_q;
        count_d = count_q;
        if (reset) begin
            head_d  = DATA_RESET;
            tail_d  = DATA_RESET;
            count_d = CNT_ZERO;
        end else if (push && pop) begin
            if (count_q == CNT_ONE) begin
                head_d = fill.data;
            end else begin
                head_d = tail_q;
                tail_d = fill.data;
            end
        end else if (pop) begin
            if (count_q == CNT_FULL) begin
                head_d = tail_q;
            end
            count_d = count_q - CNT_ONE;
        end else if (push) begin
            if (count_q == CNT_ZERO) begin
                head_d = fill.data;
            end else begin
                tail_d = fill.data;
            end
            count_d = count_q + CNT_ONE;
        end
    end

    // Head keeps its word when drained empty: outputs hold
    always_ff @(posedge clk) begin
        head_q  <= head_d;
        tail_q  <= tail_d;
        count_q <= count_d;
    end

endmodule : word_buffer

// >>> rtl/registered_cmd_buffer_parity.sv
`timescale 1ns/1ps
module registered_cmd_buffer_parity import cmd_buf_pkg::*; (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              cs_gate_enable,
    input  wire logic              chip_select_in_0,
    input  wire logic              chip_select_in_1,
    input  wire logic              odt_in_0,
    input  wire logic              odt_in_1,
    input  wire logic              cke_in_0,
    input  wire logic              cke_in_1,
    input  wire logic [DATA_W-1:0] data_in,
    input  wire logic              parity_in,
    input  wire logic              out_ready,
    output logic                   cmd_ready,
    output logic                   out_valid,
    output logic      [DATA_W-1:0] data_out_a,
    output logic      [DATA_W-1:0] data_out_b,
    output logic                   chip_select_out_0a,
    output logic                   chip_select_out_1a,
    output logic                   chip_select_out_0b,
    output logic                   chip_select_out_1b,
    output logic                   odt_out_0a,
    output logic                   odt_out_1a,
    output logic                   odt_out_0b,
    output logic                   odt_out_1b,
    output logic                   cke_out_0a,
    output logic                   cke_out_1a,
    output logic                   cke_out_0b,
    output logic                   cke_out_1b,
    output logic                   low_power_mode,
    output logic                   parity_error_n,
    output logic                   parity_error_drive,
    output logic                   parity_error_oe,
    input  wire logic              parity_error_sense
);

    // ------------------------------------------------------------
    // Decoded input conditions
    // ------------------------------------------------------------
    logic cs_any_low;
    logic lpm_now;
    logic capture_data;

    assign cs_any_low   = !chip_select_in_0 || !chip_select_in_1;
    assign lpm_now      = cs_gate_enable && !cs_any_low;
    assign capture_data = !cs_gate_enable || cs_any_low;

    // ------------------------------------------------------------
    // Data path through the two-entry buffer
    // ------------------------------------------------------------
    word_stream_if fill_bus ();
    word_stream_if drain_bus ();

    // A stalled receiver backs up into the buffer, then refuses.
    // Limitation: the controller cannot be stalled, so a word that
    // meets a full buffer is lost; cmd_ready low shows it.
    assign fill_bus.valid  = capture_data;
    assign fill_bus.data   = data_in;
    assign drain_bus.ready = out_ready;
    assign cmd_ready       = fill_bus.ready;
    assign out_valid       = drain_bus.valid;

    word_buffer u_word_buffer (
        .clk   (clk),
        .reset (reset),
        .fill  (fill_bus),
        .drain (drain_bus)
    );

    // Both copies come from the same head register
    assign data_out_a = drain_bus.data;
    assign data_out_b = drain_bus.data;

    // ------------------------------------------------------------
    // Ungated control registers
    // ------------------------------------------------------------
    logic [1:0] cs_q;
    logic [1:0] cs_d;
    logic [1:0] odt_q;
    logic [1:0] odt_d;
    logic [1:0] cke_q;
    logic [1:0] cke_d;
    logic       lpm_q;
    logic       lpm_d;

    // Reset is taken on the clock, so one edge clears every stage
    always_comb begin
        cs_d  = cs_q;
        odt_d = odt_q;
        cke_d = cke_q;
        lpm_d = lpm_q;
        if (reset) begin
            cs_d  = PAIR_RESET;
            odt_d = PAIR_RESET;
            cke_d = PAIR_RESET;
            lpm_d = 1'b0;
        end else begin
            cs_d  = {chip_select_in_1, chip_select_in_0};
            odt_d = {odt_in_1, odt_in_0};
            cke_d = {cke_in_1, cke_in_0};
            lpm_d = lpm_now;
        end
    end

    always_ff @(posedge clk) begin
        cs_q  <= cs_d;
        odt_q <= odt_d;
        cke_q <= cke_d;
        lpm_q <= lpm_d;
    end

    assign chip_select_out_0a = cs_q[0];
    assign chip_select_out_0b = cs_q[0];
    assign chip_select_out_1a = cs_q[1];
    assign chip_select_out_1b = cs_q[1];
    assign odt_out_0a         = odt_q[0];
    assign odt_out_0b         = odt_q[0];
    assign odt_out_1a         = odt_q[1];
    assign odt_out_1b         = odt_q[1];
    assign cke_out_0a         = cke_q[0];
    assign cke_out_0b         = cke_q[0];
    assign cke_out_1a         = cke_q[1];
    assign cke_out_1b         = cke_q[1];
    assign low_power_mode     = lpm_q;

    // ------------------------------------------------------------
    // Parity stage 1: word of the data cycle
    // ------------------------------------------------------------
    // Captured every edge regardless of the gate, so the check
    // sees the word even when the data copies are held.
    logic [DATA_W-1:0] pdata_q;
    logic [DATA_W-1:0] pdata_d;
    logic              pcs_q;
    logic              pcs_d;
    logic              plpm_q;
    logic              plpm_d;

    always_comb begin
        pdata_d = pdata_q;
        pcs_d   = pcs_q;
        plpm_d  = plpm_q;
        if (reset) begin
            pdata_d = DATA_RESET;
            pcs_d   = 1'b0;
            plpm_d  = 1'b0;
        end else begin
            pdata_d = data_in;
            pcs_d   = cs_any_low;
            plpm_d  = lpm_now;
        end
    end

    always_ff @(posedge clk) begin
        pdata_q <= pdata_d;
        pcs_q   <= pcs_d;
        plpm_q  <= plpm_d;
    end

    // ------------------------------------------------------------
    // Parity stage 2: late parity bit meets its word
    // ------------------------------------------------------------
    logic err_q;
    logic err_d;
    logic hold_q;
    logic hold_d;
    logic hlpm_q;
    logic hlpm_d;

    // Select state travels with the word, so the hold lands on
    // the same edge as the error that word would have carried.
    always_comb begin
        err_d  = err_q;
        hold_d = hold_q;
        hlpm_d = hlpm_q;
        if (reset) begin
            err_d  = 1'b0;
            hold_d = 1'b0;
            hlpm_d = 1'b0;
        end else begin
            // Only the data word and parity bit enter the sum
            err_d  = pcs_q && parity_odd(pdata_q, parity_in);
            hold_d = !pcs_q;
            hlpm_d = plpm_q;
        end
    end

    always_ff @(posedge clk) begin
        err_q  <= err_d;
        hold_q <= hold_d;
        hlpm_q <= hlpm_d;
    end

    // ------------------------------------------------------------
    // Parity stage 3: latched error output
    // ------------------------------------------------------------
    // The counter holds the low cycles still owed after this one.
    logic             perr_n_q;
    logic             perr_n_d;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] low_cnt_d;

    always_comb begin
        perr_n_d  = perr_n_q;
        low_cnt_d = low_cnt_q;
        if (reset) begin
            perr_n_d  = PERR_IDLE_N;
            low_cnt_d = CNT_ZERO;
        end else if (hold_q) begin
            // Frozen output; an error alive in low power owes a tail
            if (hlpm_q && !perr_n_q) begin
                low_cnt_d = LPM_HOLD_CNT;
            end
        end else if (err_q) begin
            perr_n_d  = 1'b0;
            low_cnt_d = ERR_HOLD_CNT;
        end else if (low_cnt_q != CNT_ZERO) begin
            perr_n_d  = 1'b0;
            low_cnt_d = low_cnt_q - CNT_ONE;
        end else begin
            perr_n_d  = PERR_IDLE_N;
        end
    end

    always_ff @(posedge clk) begin
        perr_n_q  <= perr_n_d;
        low_cnt_q <= low_cnt_d;
    end

    // Open-drain: only ever pulls low, released when idle
    assign parity_error_n     = perr_n_q;
    assign parity_error_drive = 1'b0;
    assign parity_error_oe    = !perr_n_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Outputs are sampled one edge after the edge that launches
    // them, hence the extra cycle in the error timing checks.
    a_reset_clears: assert property (
        @(posedge clk) reset |=> (parity_error_n && !parity_error_oe
            && (data_out_a == DATA_RESET) && (cs_q == PAIR_RESET)
            && (odt_q == PAIR_RESET) && (cke_q == PAIR_RESET)))
        else $error("outputs not cleared by reset");

    a_select_follow: assert property (
        @(posedge clk) disable iff (reset)
        !reset |=> ((chip_select_out_0a == $past(chip_select_in_0))
            && (chip_select_out_1b == $past(chip_select_in_1))))
        else $error("select copy did not follow input");

    a_odt_cke_follow: assert property (
        @(posedge clk) disable iff (reset)
        !reset |=> ((odt_out_0b == $past(odt_in_0))
            && (odt_out_1a == $past(odt_in_1))
            && (cke_out_0a == $past(cke_in_0))
            && (cke_out_1b == $past(cke_in_1))))
        else $error("odt or cke copy did not follow input");

    a_gate_open: assert property (
        @(posedge clk) disable iff (reset)
        (!cs_gate_enable && cmd_ready && out_ready)
            |=> (data_out_a == $past(data_in)))
        else $error("data not redriven with gate low");

    a_select_open: assert property (
        @(posedge clk) disable iff (reset)
        (cs_gate_enable && cs_any_low && cmd_ready && out_ready)
            |=> (data_out_b == $past(data_in)))
        else $error("data not redriven with a select low");

    a_gated_hold: assert property (
        @(posedge clk) disable iff (reset)
        (lpm_now && cmd_ready)
            |=> ($stable(data_out_a) && (data_out_a == data_out_b)))
        else $error("data copies changed while gated");

    a_error_timing: assert property (
        @(posedge clk) disable iff (reset)
        cs_any_low ##1 parity_odd($past(data_in), parity_in)
            |=> ##1 !parity_error_n)
        else $error("parity error not shown two edges after data");

    a_gate_ignored: assert property (
        @(posedge clk) disable iff (reset)
        (cs_gate_enable && cs_any_low) ##1 parity_odd($past(data_in), parity_in)
            |=> ##1 !parity_error_n)
        else $error("parity error missed with gate high");

    a_even_clean: assert property (
        @(posedge clk) disable iff (reset)
        cs_any_low ##1 !parity_odd($past(data_in), parity_in) |=> !err_q)
        else $error("error raised for an even word");

    a_gated_check: assert property (
        @(posedge clk) disable iff (reset)
        (chip_select_in_0 && chip_select_in_1) |=> ##2 $stable(parity_error_n))
        else $error("error output moved for an unselected word");

    a_lpm_flag: assert property (
        @(posedge clk) disable iff (reset)
        1'b1 |=> (low_power_mode
            == $past(cs_gate_enable && chip_select_in_0 && chip_select_in_1)))
        else $error("low power flag does not match inputs");

    a_stall_keep: assert property (
        @(posedge clk) disable iff (reset)
        (out_valid && !out_ready) |=> $stable(data_out_a))
        else $error("held word changed while receiver stalled");

    a_latch_min: assert property (
        @(posedge clk) disable iff (reset)
        $fell(parity_error_n) |=> !parity_error_n)
        else $error("error released after one cycle");

    a_run_low: assert property (
        @(posedge clk) disable iff (reset)
        err_q[*2] |=> !parity_error_n)
        else $error("error released during error run");

    a_lpm_freeze: assert property (
        @(posedge clk) disable iff (reset)
        hold_q |=> $stable(parity_error_n))
        else $error("error output moved in low power");

    a_lpm_tail: assert property (
        @(posedge clk) disable iff (reset)
        (hold_q && hlpm_q && !parity_error_n) ##1 !hold_q
            |=> !parity_error_n [*2])
        else $error("error tail after low power too short");

endmodule : registered_cmd_buffer_parity

// >>> verif/ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Controller side: data, selects and late parity
// ------------------------------------------------------------
module ctrl_model import cmd_buf_pkg::*; (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [DATA_W-1:0] next_word,
    input  wire logic              next_bad,
    input  wire logic              next_cs0,
    input  wire logic              next_cs1,
    input  wire logic              next_gate,
    output logic      [DATA_W-1:0] data_in,
    output logic                   parity_in,
    output logic                   chip_select_in_0,
    output logic                   chip_select_in_1,
    output logic                   cs_gate_enable
);
    logic bad_q;

    initial begin
        {data_in, parity_in, chip_select_in_0, chip_select_in_1, cs_gate_enable, bad_q} = '0;
    end

    always @(posedge clk) begin
        if (reset) begin
            // Quiet low lines so no false error follows release
            {data_in, parity_in, chip_select_in_0, chip_select_in_1} <= '0;
            cs_gate_enable <= 1'b0;
            bad_q          <= 1'b0;
        end else begin
            data_in          <= next_word;
            chip_select_in_0 <= next_cs0;
            chip_select_in_1 <= next_cs1;
            cs_gate_enable   <= next_gate;
            bad_q            <= next_bad;
            // Bit covers the word now on the pins, one edge late
            parity_in        <= (^data_in) ^ bad_q;
        end
    end
endmodule : ctrl_model

// >>> verif/test_registered_cmd_buffer_parity.sv
`timescale 1ns/1ps
module test_registered_cmd_buffer_parity import cmd_buf_pkg::*;;
    logic              clk = 1'b0, reset = 1'b1, out_ready = 1'b1, parity_error_sense = 1'b0;
    logic              next_bad = 1'b0, next_cs0 = 1'b0, next_cs1 = 1'b0, next_gate = 1'b0;
    logic [DATA_W-1:0] next_word = '0, data_in, data_out_a, data_out_b;
    logic [3:0]        ctl = 4'h0;
    logic              odt_in_0, odt_in_1, cke_in_0, cke_in_1, parity_in, cs_gate_enable;
    logic              chip_select_in_0, chip_select_in_1, cmd_ready, out_valid;
    logic              chip_select_out_0a, chip_select_out_1a, chip_select_out_0b;
    logic              chip_select_out_1b, odt_out_0a, odt_out_1a, odt_out_0b, odt_out_1b;
    logic              cke_out_0a, cke_out_1a, cke_out_0b, cke_out_1b, low_power_mode;
    logic              parity_error_n, parity_error_drive, parity_error_oe;
    int                bad_count = 0, total_checks = 0;
    assign {cke_in_1, cke_in_0, odt_in_1, odt_in_0} = ctl;
    wire [1:0] cs_a  = {chip_select_out_1a, chip_select_out_0a};
    wire [1:0] cs_b  = {chip_select_out_1b, chip_select_out_0b};
    wire [3:0] ctl_a = {cke_out_1a, cke_out_0a, odt_out_1a, odt_out_0a};
    wire [3:0] ctl_b = {cke_out_1b, cke_out_0b, odt_out_1b, odt_out_0b};

    always #12.5 clk = ~clk;

    ctrl_model ctrl (.clk, .reset, .next_word, .next_bad, .next_cs0, .next_cs1, .next_gate,
        .data_in, .parity_in, .chip_select_in_0, .chip_select_in_1, .cs_gate_enable);

    registered_cmd_buffer_parity dut (.clk, .reset, .cs_gate_enable, .chip_select_in_0,
        .chip_select_in_1, .odt_in_0, .odt_in_1, .cke_in_0, .cke_in_1, .data_in, .parity_in,
        .out_ready, .cmd_ready, .out_valid, .data_out_a, .data_out_b, .chip_select_out_0a,
        .chip_select_out_1a, .chip_select_out_0b, .chip_select_out_1b, .odt_out_0a,
        .odt_out_1a, .odt_out_0b, .odt_out_1b, .cke_out_0a, .cke_out_1a, .cke_out_0b,
        .cke_out_1b, .low_power_mode, .parity_error_n, .parity_error_drive,
        .parity_error_oe, .parity_error_sense);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : at

    task automatic send(input logic [DATA_W-1:0] w, input logic c0, c1, g, bad,
                        input logic [3:0] c);
        @(posedge clk);
        {next_word, next_cs0, next_cs1, next_gate, next_bad, ctl} <= {w, c0, c1, g, bad, c};
    endtask : send

    task automatic idle();
        send(22'h000000, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
    endtask : idle

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        at(15);
        chk("data_out_a", 22'h0, data_out_a);
        chk("data_out_b", 22'h0, data_out_b);
        chk("copies", 22'h0, {cs_a, cs_b, ctl_a, ctl_b, low_power_mode, out_valid});
        chk("parity_error_n", 22'h1, parity_error_n);
        chk("parity_error_oe", 22'h0, parity_error_oe);
        chk("cmd_ready", 22'h1, cmd_ready);
        @(posedge clk);
        reset <= 1'b0;
        $display("t_reset finished");
    endtask : t_reset

    task automatic t_pass();
        send(22'h2a5c3e, 1'b1, 1'b1, 1'b0, 1'b0, 4'h5);
        idle();
        #1;
        chk("ctl_a", 22'h5, ctl_a);
        chk("ctl_b", 22'h5, ctl_b);
        at(1);
        chk("data_out_a", 22'h2a5c3e, data_out_a);
        chk("data_out_b", 22'h2a5c3e, data_out_b);
        chk("cs_a", 22'h3, cs_a);
        chk("cs_b", 22'h3, cs_b);
        chk("ctl_a", 22'h0, ctl_a);
        $display("t_pass finished");
    endtask : t_pass

    task automatic t_gate();
        send(22'h13579b, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
        send(22'h3c3c3c, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
        send(22'h0f0f0f, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
        idle();
        #1;
        chk("data_out_a", 22'h13579b, data_out_a);
        chk("data_out_b", 22'h13579b, data_out_b);
        chk("low_power_mode", 22'h1, low_power_mode);
        chk("cs_a", 22'h3, cs_a);
        at(1);
        chk("data_out_a", 22'h0f0f0f, data_out_a);
        chk("low_power_mode", 22'h0, low_power_mode);
        $display("t_gate finished");
    endtask : t_gate

    task automatic t_perr();
        // Gate high with a select low: check must still run
        send(22'h000007, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
        idle();
        at(2);
        chk("parity_error_n", 22'h1, parity_error_n);
        at(1);
        chk("parity_error_n", 22'h0, parity_error_n);
        chk("parity_error_oe", 22'h1, parity_error_oe);
        chk("parity_error_drive", 22'h0, parity_error_drive);
        at(1);
        chk("parity_error_n", 22'h0, parity_error_n);
        at(1);
        chk("parity_error_n", 22'h1, parity_error_n);
        $display("t_perr finished");
    endtask : t_perr

    task automatic t_run();
        repeat (3) send(22'h100001, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
        idle();
        repeat (3) begin
            at(1);
            chk("parity_error_n", 22'h0, parity_error_n);
        end
        at(3);
        chk("parity_error_n", 22'h1, parity_error_n);
        $display("t_run finished");
    endtask : t_run

    task automatic t_nochk();
        // Bad bit with no select, then a clean word beside odd side bits
        send(22'h000001, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
        send(22'h000003, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        send(22'h000000, 1'b0, 1'b1, 1'b0, 1'b0, 4'h7);
        at(2);
        chk("parity_error_n", 22'h1, parity_error_n);
        at(1);
        chk("parity_error_n", 22'h1, parity_error_n);
        $display("t_nochk finished");
    endtask : t_nochk

    task automatic t_tail();
        // Error just before low power owes two cycles after it ends
        send(22'h000001, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
        repeat (2) send(22'h000000, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
        idle();
        at(1);
        chk("parity_error_n", 22'h0, parity_error_n);
        at(4);
        chk("parity_error_n", 22'h0, parity_error_n);
        at(1);
        chk("parity_error_n", 22'h1, parity_error_n);
        $display("t_tail finished");
    endtask : t_tail

    task automatic t_rerr();
        // Reset lands on the edge where the latched error would end anyway
        send(22'h000001, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
        idle();
        at(3);
        chk("parity_error_n", 22'h0, parity_error_n);
        @(posedge clk);
        reset <= 1'b1;
        at(1);
        chk("parity_error_n", 22'h1, parity_error_n);
        chk("data_out_a", 22'h0, data_out_a);
        chk("out_valid", 22'h0, out_valid);
        @(posedge clk);
        reset <= 1'b0;
        at(3);
        chk("parity_error_n", 22'h1, parity_error_n);
        $display("t_rerr finished");
    endtask : t_rerr

    task automatic t_stall();
        send(22'h000000, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
        at(2);
        out_ready <= 1'b0;
        send(22'h111111, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        send(22'h222222, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        send(22'h333333, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
        send(22'h000000, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
        at(1);
        chk("cmd_ready", 22'h0, cmd_ready);
        chk("out_valid", 22'h1, out_valid);
        chk("data_out_a", 22'h111111, data_out_a);
        out_ready <= 1'b1;
        at(1);
        chk("data_out_b", 22'h222222, data_out_b);
        at(1);
        chk("out_valid", 22'h0, out_valid);
        chk("data_out_a", 22'h222222, data_out_a);
        $display("t_stall finished");
    endtask : t_stall

    initial begin
        t_reset();
        t_pass();
        t_gate();
        t_perr();
        t_run();
        t_nochk();
        t_tail();
        t_stall();
        t_rerr();
        give_verdict();
    end

    // Whole run is near 80 cycles; 3000 cycles, nearly forty times that, means a hang
    initial begin
        #(25ns * 3000);
        bad_count++;
        give_verdict();
    end
endmodule : test_registered_cmd_buffer_parity
